//--- codec_port_pkg.sv
// Shared constants for the codec serial port FIFO status block.
// Assumes a single system clock and an AHB-Lite register bus.
package codec_port_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET         = 8'h00;
  localparam logic [7:0] STATUS_OFFSET       = 8'h04;
  localparam logic [7:0] AUDIO_DATA_OFFSET   = 8'h08;
  localparam logic [7:0] TELECOM_DATA_OFFSET = 8'h0c;

  // Control register fields
  localparam int CTRL_ENABLE_BIT           = 0;
  localparam int CTRL_AUDIO_RX_MASK_BIT    = 1;
  localparam int CTRL_TELECOM_TX_MASK_BIT  = 2;
  localparam int CTRL_TELECOM_RX_MASK_BIT  = 3;
  localparam int CTRL_WIDTH                = 4;
  localparam logic [3:0] CTRL_RESET        = 4'h0;

  // Status register fields
  localparam int ST_AUDIO_RX_SERVICE   = 1;
  localparam int ST_TELECOM_TX_SERVICE = 2;
  localparam int ST_TELECOM_RX_SERVICE = 3;
  localparam int ST_AUDIO_UNDERRUN     = 4;
  localparam int ST_AUDIO_OVERRUN      = 5;
  localparam int ST_TELECOM_UNDERRUN   = 6;
  localparam int ST_TELECOM_OVERRUN    = 7;
  localparam int ST_AUDIO_TX_NOT_FULL  = 8;
  localparam int ST_AUDIO_RX_NOT_EMPTY = 9;
  localparam int ST_TELECOM_TX_NOT_FULL  = 10;
  localparam int ST_TELECOM_RX_NOT_EMPTY = 11;

  // FIFO shape and service thresholds
  localparam int FIFO_DEPTH       = 8;
  localparam int SAMPLE_WIDTH     = 16;
  localparam int RX_SERVICE_LEVEL = 4;
  localparam int TX_SERVICE_LEVEL = 4;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

//--- sample_fifo.sv
// Synchronous sample FIFO with occupancy count.
// Assumes push is never issued when full nor pop when empty.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic                       sys_clk,   // System clock
  input  wire logic                       reset,     // Synchronous reset
  input  wire logic                       push,      // Write one entry
  input  wire logic [WIDTH-1:0]           push_data, // Entry to write
  input  wire logic                       pop,       // Remove head entry
  output logic      [WIDTH-1:0]           pop_data,  // Head entry
  output logic      [$clog2(DEPTH+1)-1:0] count,     // Valid entries
  output logic                            full,      // No free entry
  output logic                            empty      // No valid entry
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
    $error("sample_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;

  assign pop_data = mem[rd_ptr];
  assign full     = (count == CW'(DEPTH));
  assign empty    = (count == '0);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + CW'(1);
    end else if (pop && !push) begin
      count <= count - CW'(1);
    end
  end

endmodule
`default_nettype wire

//--- codec_port_fifo_status_flags.sv
// Codec serial port FIFOs with service, error and polled flags,
// reached over AHB-Lite. The serial shifters sit outside on the
// same clock and exchange one sample per strobe.
`timescale 1ns/1ps
`default_nettype none
module codec_port_fifo_status_flags
  import codec_port_pkg::*;
#(
  parameter int DEPTH = codec_port_pkg::FIFO_DEPTH,
  parameter int WIDTH = codec_port_pkg::SAMPLE_WIDTH
) (
  input  wire logic             sys_clk,               // System clock
  input  wire logic             reset,                 // Sync reset, high
  input  wire logic             hsel,                  // Slave select
  input  wire logic [31:0]      haddr,                 // Byte address
  input  wire logic [1:0]       htrans,                // Transfer type
  input  wire logic             hwrite,                // Write when high
  input  wire logic [2:0]       hsize,                 // Word only
  input  wire logic [31:0]      hwdata,                // Write data
  input  wire logic             hready,                // Bus ready
  output logic      [31:0]      hrdata,                // Read data
  output logic                  hreadyout,             // Slave ready
  output logic                  hresp,                 // Always OKAY
  input  wire logic             audio_tx_fetch,        // Shifter takes sample
  output logic      [WIDTH-1:0] audio_tx_sample,       // Sample to send
  input  wire logic             telecom_tx_fetch,      // Shifter takes sample
  output logic      [WIDTH-1:0] telecom_tx_sample,     // Sample to send
  input  wire logic             audio_rx_strobe,       // Received sample
  input  wire logic [WIDTH-1:0] audio_rx_sample,       // Received data
  input  wire logic             telecom_rx_strobe,     // Received sample
  input  wire logic [WIDTH-1:0] telecom_rx_sample,     // Received data
  output logic                  audio_rx_dma_req,      // DMA service
  output logic                  telecom_tx_dma_req,    // DMA service
  output logic                  telecom_rx_dma_req,    // DMA service
  output logic                  irq_request            // Interrupt level
);

  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH <= RX_SERVICE_LEVEL || DEPTH <= TX_SERVICE_LEVEL) begin : g_check
    $error("FIFO depth must exceed the service thresholds");
  end
  if (WIDTH > 32) begin : g_width_check
    $error("Sample width must fit a bus word");
  end

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic sticky_next(input logic cur,
                                       input logic set,
                                       input logic clr);
    // A set in the clearing cycle wins so no event is lost
    sticky_next = set | (cur & ~clr);
  endfunction

  function automatic logic rx_service(input logic [CW-1:0] cnt,
                                      input logic en);
    rx_service = en & (cnt >= CW'(RX_SERVICE_LEVEL));
  endfunction

  function automatic logic tx_service(input logic [CW-1:0] cnt,
                                      input logic en);
    tx_service = en & (cnt <= CW'(TX_SERVICE_LEVEL));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic [CTRL_WIDTH-1:0] ctrl;
  logic                  port_enable;
  logic                  audio_rx_irq_mask;
  logic                  telecom_tx_irq_mask;
  logic                  telecom_rx_irq_mask;

  logic             bus_take;
  logic             bus_read;
  logic             wr_pending;
  logic [7:0]       wr_addr;
  logic             wr_ctrl;
  logic             wr_status;
  logic             wr_audio;
  logic             wr_telecom;

  logic             audio_rx_service_flag;
  logic             telecom_tx_service_flag;
  logic             telecom_rx_service_flag;
  logic             audio_underrun_bit;
  logic             audio_overrun_bit;
  logic             telecom_underrun_bit;
  logic             telecom_overrun_bit;
  logic             audio_tx_not_full_flag;
  logic             audio_rx_not_empty_flag;
  logic             telecom_tx_not_full_flag;
  logic             telecom_rx_not_empty_flag;

  logic             atx_push, atx_pop, atx_full, atx_empty;
  logic             arx_push, arx_pop, arx_full, arx_empty;
  logic             ttx_push, ttx_pop, ttx_full, ttx_empty;
  logic             trx_push, trx_pop, trx_full, trx_empty;
  logic [WIDTH-1:0] atx_head, arx_head, ttx_head, trx_head;
  logic [CW-1:0]    arx_count, ttx_count, trx_count;

  logic             audio_underrun_set;
  logic             audio_overrun_set;
  logic             telecom_underrun_set;
  logic             telecom_overrun_set;
  logic [31:0]      status_word;
  logic [31:0]      next_rdata;

  assign port_enable         = ctrl[CTRL_ENABLE_BIT];
  assign audio_rx_irq_mask   = ctrl[CTRL_AUDIO_RX_MASK_BIT];
  assign telecom_tx_irq_mask = ctrl[CTRL_TELECOM_TX_MASK_BIT];
  assign telecom_rx_irq_mask = ctrl[CTRL_TELECOM_RX_MASK_BIT];

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  assign hreadyout = 1'h1;
  assign hresp     = HRESP_OKAY;
  assign bus_take  = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign bus_read  = bus_take && !hwrite;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_pending <= 1'h0;
      wr_addr    <= 8'h00;
    end else begin
      wr_pending <= bus_take && hwrite;
      wr_addr    <= haddr[7:0];
    end
  end

  assign wr_ctrl    = wr_pending && (wr_addr == CTRL_OFFSET);
  assign wr_status  = wr_pending && (wr_addr == STATUS_OFFSET);
  assign wr_audio   = wr_pending && (wr_addr == AUDIO_DATA_OFFSET);
  assign wr_telecom = wr_pending && (wr_addr == TELECOM_DATA_OFFSET);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= hwdata[CTRL_WIDTH-1:0];
    end
  end

  always_comb begin
    status_word                          = 32'h0;
    status_word[ST_AUDIO_RX_SERVICE]     = audio_rx_service_flag;
    status_word[ST_TELECOM_TX_SERVICE]   = telecom_tx_service_flag;
    status_word[ST_TELECOM_RX_SERVICE]   = telecom_rx_service_flag;
    status_word[ST_AUDIO_UNDERRUN]       = audio_underrun_bit;
    status_word[ST_AUDIO_OVERRUN]        = audio_overrun_bit;
    status_word[ST_TELECOM_UNDERRUN]     = telecom_underrun_bit;
    status_word[ST_TELECOM_OVERRUN]      = telecom_overrun_bit;
    status_word[ST_AUDIO_TX_NOT_FULL]    = audio_tx_not_full_flag;
    status_word[ST_AUDIO_RX_NOT_EMPTY]   = audio_rx_not_empty_flag;
    status_word[ST_TELECOM_TX_NOT_FULL]  = telecom_tx_not_full_flag;
    status_word[ST_TELECOM_RX_NOT_EMPTY] = telecom_rx_not_empty_flag;
  end

  // Data registers pop the receive FIFO on read; an empty one reads zero
  always_comb begin
    next_rdata = 32'h0;
    case (haddr[7:0])
      CTRL_OFFSET:         next_rdata[CTRL_WIDTH-1:0] = ctrl;
      STATUS_OFFSET:       next_rdata = status_word;
      AUDIO_DATA_OFFSET:   next_rdata[WIDTH-1:0] = arx_empty ? '0 : arx_head;
      TELECOM_DATA_OFFSET: next_rdata[WIDTH-1:0] = trx_empty ? '0 : trx_head;
      default:             next_rdata = 32'h0;
    endcase
  end

  // Captured in the address phase so hrdata stands for the data phase
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hrdata <= 32'h0;
    end else if (bus_read) begin
      hrdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // FIFOs

  // Writes to a full transmit FIFO are dropped; software polls not-full
  assign atx_push = wr_audio && !atx_full;
  assign ttx_push = wr_telecom && !ttx_full;
  assign atx_pop  = port_enable && audio_tx_fetch && !atx_empty;
  assign ttx_pop  = port_enable && telecom_tx_fetch && !ttx_empty;

  assign arx_push = port_enable && audio_rx_strobe && !arx_full;
  assign trx_push = port_enable && telecom_rx_strobe && !trx_full;
  assign arx_pop  = bus_read && (haddr[7:0] == AUDIO_DATA_OFFSET) && !arx_empty;
  assign trx_pop  = bus_read && (haddr[7:0] == TELECOM_DATA_OFFSET) && !trx_empty;

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_audio_tx (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (atx_push),
    .push_data (hwdata[WIDTH-1:0]),
    .pop       (atx_pop),
    .pop_data  (atx_head),
    .count     (),
    .full      (atx_full),
    .empty     (atx_empty)
  );

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_audio_rx (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (arx_push),
    .push_data (audio_rx_sample),
    .pop       (arx_pop),
    .pop_data  (arx_head),
    .count     (arx_count),
    .full      (arx_full),
    .empty     (arx_empty)
  );

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_telecom_tx (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (ttx_push),
    .push_data (hwdata[WIDTH-1:0]),
    .pop       (ttx_pop),
    .pop_data  (ttx_head),
    .count     (ttx_count),
    .full      (ttx_full),
    .empty     (ttx_empty)
  );

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_telecom_rx (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (trx_push),
    .push_data (telecom_rx_sample),
    .pop       (trx_pop),
    .pop_data  (trx_head),
    .count     (trx_count),
    .full      (trx_full),
    .empty     (trx_empty)
  );

  ////////////////////////////////////////////////////////////////////
  // Transmit samples: an empty fetch keeps the last one on the line

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      audio_tx_sample <= '0;
    end else if (atx_pop) begin
      audio_tx_sample <= atx_head;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      telecom_tx_sample <= '0;
    end else if (ttx_pop) begin
      telecom_tx_sample <= ttx_head;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky error bits, cleared by writing one

  assign audio_underrun_set   = port_enable && audio_tx_fetch && atx_empty;
  assign telecom_underrun_set = port_enable && telecom_tx_fetch && ttx_empty;
  assign audio_overrun_set    = port_enable && audio_rx_strobe && arx_full;
  assign telecom_overrun_set  = port_enable && telecom_rx_strobe && trx_full;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      audio_underrun_bit   <= 1'h0;
      audio_overrun_bit    <= 1'h0;
      telecom_underrun_bit <= 1'h0;
      telecom_overrun_bit  <= 1'h0;
    end else begin
      audio_underrun_bit   <= sticky_next(audio_underrun_bit, audio_underrun_set,
                                          wr_status && hwdata[ST_AUDIO_UNDERRUN]);
      audio_overrun_bit    <= sticky_next(audio_overrun_bit, audio_overrun_set,
                                          wr_status && hwdata[ST_AUDIO_OVERRUN]);
      telecom_underrun_bit <= sticky_next(telecom_underrun_bit, telecom_underrun_set,
                                          wr_status && hwdata[ST_TELECOM_UNDERRUN]);
      telecom_overrun_bit  <= sticky_next(telecom_overrun_bit, telecom_overrun_set,
                                          wr_status && hwdata[ST_TELECOM_OVERRUN]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Service and polled flags, refreshed every cycle from occupancy

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      audio_rx_service_flag   <= 1'h0;
      telecom_tx_service_flag <= 1'h0;
      telecom_rx_service_flag <= 1'h0;
    end else begin
      audio_rx_service_flag   <= rx_service(arx_count, port_enable);
      telecom_tx_service_flag <= tx_service(ttx_count, port_enable);
      telecom_rx_service_flag <= rx_service(trx_count, port_enable);
    end
  end

  // Polled flags feed only the status word, never the interrupt
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      audio_tx_not_full_flag    <= 1'h1;
      audio_rx_not_empty_flag   <= 1'h0;
      telecom_tx_not_full_flag  <= 1'h1;
      telecom_rx_not_empty_flag <= 1'h0;
    end else begin
      audio_tx_not_full_flag    <= !atx_full;
      audio_rx_not_empty_flag   <= !arx_empty;
      telecom_tx_not_full_flag  <= !ttx_full;
      telecom_rx_not_empty_flag <= !trx_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Requests: DMA copies of flops, irq an OR of masked service flops and unmasked error flops, so they follow their bits exactly

  assign audio_rx_dma_req   = audio_rx_service_flag;
  assign telecom_tx_dma_req = telecom_tx_service_flag;
  assign telecom_rx_dma_req = telecom_rx_service_flag;

  assign irq_request = (audio_rx_service_flag && audio_rx_irq_mask)
                     | (telecom_tx_service_flag && telecom_tx_irq_mask)
                     | (telecom_rx_service_flag && telecom_rx_irq_mask)
                     | audio_underrun_bit | audio_overrun_bit
                     | telecom_underrun_bit | telecom_overrun_bit;

endmodule
`default_nettype wire

//--- codec_shifter_model.sv
// Serial shifter stand-in: sends receive samples and fetches transmit samples.
// Assumes the block takes strobes and fetches on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module codec_shifter_model (
  input  wire logic        sys_clk,           // System clock
  output logic             audio_tx_fetch,    // Take audio sample
  output logic             telecom_tx_fetch,  // Take telecom sample
  output logic             audio_rx_strobe,   // Audio sample valid
  output logic      [15:0] audio_rx_sample,   // Audio data
  output logic             telecom_rx_strobe, // Telecom sample valid
  output logic      [15:0] telecom_rx_sample  // Telecom data
);
  initial begin
    {audio_tx_fetch, telecom_tx_fetch, audio_rx_strobe, telecom_rx_strobe} = 4'h0;
    audio_rx_sample = 16'h0000;
    telecom_rx_sample = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One sample per cycle; a full FIFO is not waited for, as on the real line
  task automatic send(input bit tel, input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (tel) begin
        telecom_rx_strobe <= 1'b1;
        telecom_rx_sample <= base + 16'(i);
      end else begin
        audio_rx_strobe <= 1'b1;
        audio_rx_sample <= base + 16'(i);
      end
    end
    @(posedge sys_clk);
    audio_rx_strobe <= 1'b0;
    telecom_rx_strobe <= 1'b0;
    // Released data must not look valid, so it is inverted
    audio_rx_sample <= ~audio_rx_sample;
    telecom_rx_sample <= ~telecom_rx_sample;
  endtask
  task automatic fetch(input bit tel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (tel) telecom_tx_fetch <= 1'b1;
      else audio_tx_fetch <= 1'b1;
    end
    @(posedge sys_clk);
    audio_tx_fetch <= 1'b0;
    telecom_tx_fetch <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- codec_port_fifo_status_flags_chk.sv
// Port checker for the codec port FIFO status block.
// Assumes a zero-wait bus slave; tracks control and audio rx fill itself.
`timescale 1ns/1ps
`default_nettype none
module codec_port_chk
  import codec_port_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic             sys_clk,            // Clock
  input wire logic             reset,              // Sync reset
  input wire logic             hsel,               // Select
  input wire logic [31:0]      haddr,              // Address
  input wire logic [1:0]       htrans,             // Transfer type
  input wire logic             hwrite,             // Write
  input wire logic [31:0]      hwdata,             // Write data
  input wire logic             hready,             // Bus ready
  input wire logic             audio_tx_fetch,     // Audio fetch
  input wire logic [WIDTH-1:0] audio_tx_sample,    // Audio tx out
  input wire logic             telecom_tx_fetch,   // Telecom fetch
  input wire logic [WIDTH-1:0] telecom_tx_sample,  // Telecom tx out
  input wire logic             audio_rx_strobe,    // Audio rx in
  input wire logic             audio_rx_dma_req,   // DMA request
  input wire logic             telecom_tx_dma_req, // DMA request
  input wire logic             telecom_rx_dma_req, // DMA request
  input wire logic             irq_request         // Interrupt
);
  logic [3:0]                 ctrl;
  logic                       wr_ctrl;
  logic [$clog2(DEPTH+1)-1:0] cnt;
  wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire logic pop  = take && !hwrite && haddr[7:0] == AUDIO_DATA_OFFSET && cnt != 0;
  // A full FIFO refuses a sample even when a pop lands in the same cycle
  wire logic push = audio_rx_strobe && ctrl[CTRL_ENABLE_BIT] && cnt < DEPTH;
  always_ff @(posedge sys_clk) begin
    if (reset) wr_ctrl <= 1'b0;
    else wr_ctrl <= take && hwrite && haddr[7:0] == CTRL_OFFSET;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) ctrl <= CTRL_RESET;
    else if (wr_ctrl) ctrl <= hwdata[3:0];
  end
  always_ff @(posedge sys_clk) begin
    if (reset) cnt <= '0;
    else if (push && !pop) cnt <= cnt + 1'b1;
    else if (pop && !push) cnt <= cnt - 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_arx_level: assert property (ctrl[0] && $past(ctrl[0]) |->
    audio_rx_dma_req == ($past(cnt) >= RX_SERVICE_LEVEL)) else $error("audio rx request");
  a_arx_irq: assert property (audio_rx_dma_req && ctrl[1] |-> irq_request)
    else $error("audio rx irq missing");
  a_ttx_irq: assert property (telecom_tx_dma_req && ctrl[2] |-> irq_request)
    else $error("telecom tx irq missing");
  a_trx_irq: assert property (telecom_rx_dma_req && ctrl[3] |-> irq_request)
    else $error("telecom rx irq missing");
  a_off_quiet: assert property (!ctrl[0] && !$past(ctrl[0]) |->
    !(audio_rx_dma_req || telecom_tx_dma_req || telecom_rx_dma_req)) else $error("req off");
  // Reset in the antecedent: a reset pulse legally clears the held sample
  a_atx_hold: assert property (!reset && !audio_tx_fetch |=> $stable(audio_tx_sample))
    else $error("audio tx sample moved");
  a_ttx_hold: assert property (!reset && !telecom_tx_fetch |=> $stable(telecom_tx_sample))
    else $error("telecom tx sample moved");
  a_ovr_irq: assert property (audio_rx_strobe && ctrl[0] && cnt == DEPTH
    |=> irq_request [*2]) else $error("overrun irq missing");
endmodule
bind codec_port_fifo_status_flags codec_port_chk #(.DEPTH(DEPTH), .WIDTH(WIDTH)) chk_u (
  .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .audio_tx_fetch,
  .audio_tx_sample, .telecom_tx_fetch, .telecom_tx_sample, .audio_rx_strobe,
  .audio_rx_dma_req, .telecom_tx_dma_req, .telecom_rx_dma_req, .irq_request);
`default_nettype wire

//--- tb_codec_port_fifo_status_flags.sv
// Self-checking bench for the codec port FIFO status block.
// Assumes the bus slave answers with hreadyout; shifter model drives serial side.
`timescale 1ns/1ps
`default_nettype none
module tb_codec_port_fifo_status_flags;
  import codec_port_pkg::*;
  typedef struct {int n; logic [3:0] c; logic dma; logic irq;} row_t;
  logic        sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rq;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, af, tf, as, ts, ad, td, rd, irq;
  logic [15:0] asd, tsd, atx, ttx;
  wire logic   hready = hreadyout;
  int          n_errors = 0, tests_run = 0;
  row_t        rows[4] = '{'{3, 4'h3, 0, 0}, '{4, 4'h1, 1, 0}, '{4, 4'h3, 1, 1}, '{8, 4'hf, 1, 1}};
  always #50 sys_clk = ~sys_clk;
  codec_port_fifo_status_flags dut_u (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .audio_tx_fetch(af),
    .audio_tx_sample(atx), .telecom_tx_fetch(tf), .telecom_tx_sample(ttx),
    .audio_rx_strobe(as), .audio_rx_sample(asd), .telecom_rx_strobe(ts),
    .telecom_rx_sample(tsd), .audio_rx_dma_req(ad), .telecom_tx_dma_req(td),
    .telecom_rx_dma_req(rd), .irq_request(irq));
  codec_shifter_model pm_u (.sys_clk, .audio_tx_fetch(af), .telecom_tx_fetch(tf),
    .audio_rx_strobe(as), .audio_rx_sample(asd), .telecom_rx_strobe(ts),
    .telecom_rx_sample(tsd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rq = hrdata;
  endtask
  task automatic st(input string nm, input int b, input logic e);
    @(posedge sys_clk);
    bus(1'b0, STATUS_OFFSET, '0);
    chk(nm, {31'h0, e}, {31'h0, rq[b]});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("mismatch watchdog expected finish seen hang");
    close_out();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    bus(1'b0, STATUS_OFFSET, '0);
    chk("status after reset", 32'h0000_0500, rq);
    chk("requests after reset", 32'h0, {28'h0, ad, td, rd, irq});
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, CTRL_OFFSET, {28'h0, rows[i].c});
      pm_u.send(1'b0, rows[i].n, 16'(i * 256));
      repeat (2) @(posedge sys_clk);
      chk("audio_rx_dma_req", {31'h0, rows[i].dma}, {31'h0, ad});
      chk("irq_request", {31'h0, rows[i].irq}, {31'h0, irq});
      chk("telecom_tx_dma_req", 32'h1, {31'h0, td});
      for (int j = 0; j < rows[i].n; j++) begin
        bus(1'b0, AUDIO_DATA_OFFSET, '0);
        chk("audio rx data", 32'(i * 256 + j), rq);
      end
      st("audio rx not empty", ST_AUDIO_RX_NOT_EMPTY, 1'b0);
      $display("row %0d done", i);
    end
    bus(1'b1, CTRL_OFFSET, 32'h1);
    pm_u.send(1'b0, 9, 16'h0a00);
    st("audio overrun", ST_AUDIO_OVERRUN, 1'b1);
    chk("overrun irq", 32'h1, {31'h0, irq});
    for (int j = 0; j < 8; j++) begin
      bus(1'b0, AUDIO_DATA_OFFSET, '0);
      chk("kept sample", 32'h0a00 + 32'(j), rq);
    end
    bus(1'b1, STATUS_OFFSET, 32'h0);
    st("overrun after zero write", ST_AUDIO_OVERRUN, 1'b1);
    bus(1'b1, STATUS_OFFSET, 32'h1 << ST_AUDIO_OVERRUN);
    st("overrun after one write", ST_AUDIO_OVERRUN, 1'b0);
    chk("irq after clear", 32'h0, {31'h0, irq});
    $display("audio overrun test done");
    bus(1'b1, AUDIO_DATA_OFFSET, 32'h1111);
    bus(1'b1, AUDIO_DATA_OFFSET, 32'h2222);
    pm_u.fetch(1'b0, 3);
    st("audio underrun", ST_AUDIO_UNDERRUN, 1'b1);
    chk("replayed sample", 32'h2222, {16'h0, atx});
    chk("underrun irq", 32'h1, {31'h0, irq});
    bus(1'b1, AUDIO_DATA_OFFSET, 32'h3333);
    pm_u.fetch(1'b0, 1);
    @(posedge sys_clk);
    chk("sample after refill", 32'h3333, {16'h0, atx});
    bus(1'b1, STATUS_OFFSET, 32'h1 << ST_AUDIO_UNDERRUN);
    $display("audio underrun test done");
    for (int j = 0; j < 8; j++) bus(1'b1, TELECOM_DATA_OFFSET, 32'h5000 + 32'(j));
    st("telecom tx not full", ST_TELECOM_TX_NOT_FULL, 1'b0);
    chk("telecom_tx_dma_req full", 32'h0, {31'h0, td});
    pm_u.fetch(1'b1, 9);
    st("telecom underrun", ST_TELECOM_UNDERRUN, 1'b1);
    chk("telecom replay", 32'h5007, {16'h0, ttx});
    chk("telecom_tx_dma_req empty", 32'h1, {31'h0, td});
    $display("telecom tx test done");
    bus(1'b1, CTRL_OFFSET, 32'h9);
    pm_u.send(1'b1, 9, 16'h7000);
    st("telecom overrun", ST_TELECOM_OVERRUN, 1'b1);
    chk("telecom_rx_dma_req", 32'h1, {31'h0, rd});
    bus(1'b0, TELECOM_DATA_OFFSET, '0);
    chk("telecom rx head", 32'h7000, rq);
    st("telecom rx not empty", ST_TELECOM_RX_NOT_EMPTY, 1'b1);
    bus(1'b1, CTRL_OFFSET, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("requests disabled", 32'h0, {29'h0, ad, td, rd});
    $display("telecom rx and disable test done");
    // Mid-run reset with sticky bits set and entries left in a FIFO
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    bus(1'b0, STATUS_OFFSET, '0);
    chk("status after mid reset", 32'h0000_0500, rq);
    chk("irq after mid reset", 32'h0, {31'h0, irq});
    $display("mid-run reset test done");
    close_out();
  end
endmodule
`default_nettype wire
